// file: core/npw_pkg.sv
package npw_pkg;
  // bus geometry and register indices (byte address = index * 4)
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_CTRL = 10'h000;
  localparam logic [9:0] IDX_STATUS = 10'h001;
  localparam logic [9:0] IDX_RHEOSTAT0_SETTING = 10'h002;
  localparam logic [9:0] IDX_RHEOSTAT1_SETTING = 10'h003;
  localparam logic [9:0] IDX_RH0_INIT = 10'h004;
  localparam logic [9:0] IDX_RH1_INIT = 10'h005;
  localparam logic [9:0] IDX_RH0_CNT = 10'h006;
  localparam logic [9:0] IDX_RH1_CNT = 10'h007;
  localparam logic [9:0] IDX_START = 10'h0ba;
  localparam logic [9:0] IDX_PAT_FIRST = 10'h0c2;
  localparam logic [9:0] IDX_PAT_LAST = 10'h0fc;
  // pattern range as pointer values
  localparam logic [7:0] PAT_FIRST = 8'hc2;
  localparam logic [7:0] PAT_LAST = 8'hfc;
  localparam int unsigned PAT_BYTES = 59;
  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_WRAP = 2;
  localparam int unsigned CTRL_ALIGN = 3;
  localparam int unsigned CTRL_PATH0 = 4;
  localparam int unsigned CTRL_PATH1 = 5;
  localparam int unsigned CTRL_POL0 = 6;
  localparam int unsigned CTRL_POL1 = 7;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [9:0] RH_INIT_RESET = 10'h000;
  // rheostat counter limits
  localparam logic [9:0] RH_MAX = 10'h3ff;
  localparam logic [9:0] RH_MIN = 10'h000;

  typedef enum logic [1:0] {
    CONV_BYTE = 2'b00,
    CONV_NIBBLE = 2'b01,
    CONV_PAIR = 2'b10,
    CONV_SERIAL = 2'b11
  } npw_conv_e;

  typedef enum logic [2:0] {
    GS_START = 3'b001,
    GS_RUN = 3'b010,
    GS_HOLD = 3'b100
  } npw_gen_e;

  typedef struct packed {
    logic path;
    logic align;
    logic pol;
  } npw_rh_cfg_s;

  typedef struct packed {
    logic gen_clk;
    logic pattern_reset_n;
    logic [1:0] load;
    logic [1:0] step;
    logic [1:0] dir;
  } npw_matrix_in_s;

  // index of the last sub-word of a byte for a mode
  function automatic logic [2:0] npw_last_sub(input npw_conv_e m);
    case (m)
      CONV_BYTE: npw_last_sub = 3'h0;
      CONV_NIBBLE: npw_last_sub = 3'h1;
      CONV_PAIR: npw_last_sub = 3'h3;
      default: npw_last_sub = 3'h7;
    endcase
  endfunction

  // sub-word of a byte, most significant first, in the low bits
  function automatic logic [7:0] npw_subword(input logic [7:0] b,
      input npw_conv_e m, input logic [2:0] s);
    case (m)
      CONV_BYTE: npw_subword = b;
      CONV_NIBBLE: npw_subword = s[0] ? {4'h0, b[3:0]} : {4'h0, b[7:4]};
      CONV_PAIR: npw_subword = {6'h00, 2'(b >> (3'h6 - {s[1:0], 1'b0}))};
      default: npw_subword = {7'h00, b[3'h7 - s]};
    endcase
  endfunction

  // placement of a pattern byte in a 10-bit counter
  function automatic logic [9:0] npw_map(input logic [7:0] b,
      input logic align);
    npw_map = align ? {2'b00, b} : {b, 2'b00};
  endfunction
endpackage

// file: core/npw_rheostat.sv
`timescale 1ns/10ps
module npw_rheostat
  import npw_pkg::*;
#(
  parameter logic [9:0] INIT_RESET = RH_INIT_RESET
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the converter
  input wire npw_rh_cfg_s cfg,
  input wire logic [7:0] gen_data,
  input wire logic [9:0] init_value,
  input wire logic load_tick,
  input wire logic step_tick,
  input wire logic dir,
  input wire logic set_wr,
  input wire logic [9:0] set_data,
  // counter state
  output logic [9:0] setting,
  output logic [9:0] count
);
  typedef struct packed {
    logic [9:0] setting;
    logic [9:0] count;
  } npw_rh_s;

  npw_rh_s q;
  npw_rh_s next_q;
  logic up;

  // write beats load, load beats step
  always_comb begin
    next_q = q;
    up = dir ^ cfg.pol;
    if (set_wr) begin
      next_q.setting = set_data;
      next_q.count = set_data;
    end else if (load_tick) begin
      if (cfg.path) begin
        next_q.count = npw_map(gen_data, cfg.align);
      end else begin
        next_q.setting = init_value;
        next_q.count = init_value;
      end
    end else if (step_tick) begin
      // stepping works in pattern mode too, with saturation
      if (up && q.count != RH_MAX) begin
        next_q.count = q.count + 10'h001;
      end else if (!up && q.count != RH_MIN) begin
        next_q.count = q.count - 10'h001;
      end
    end
  end

  // power-on copies the stored setting into both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {INIT_RESET, INIT_RESET};
    end else begin
      q <= next_q;
    end
  end

  assign setting = q.setting;
  assign count = q.count;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_load_msb;
    load_tick && !set_wr && cfg.path && !cfg.align
      |=> count == {$past(gen_data), 2'b00};
  endproperty
  a_load_msb: assert property (p_load_msb)
    else $error("pattern load msb mapping wrong");

  property p_load_lsb;
    load_tick && !set_wr && cfg.path && cfg.align
      |=> count == {2'b00, $past(gen_data)};
  endproperty
  a_load_lsb: assert property (p_load_lsb)
    else $error("pattern load lsb mapping wrong");

  property p_reload;
    load_tick && !set_wr && !cfg.path
      |=> count == $past(init_value) && setting == count;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload of stored setting wrong");

  property p_write;
    set_wr |=> count == $past(set_data) && setting == $past(set_data);
  endproperty
  a_write: assert property (p_write)
    else $error("setting write did not reach counter");

  property p_sat;
    step_tick && !set_wr && !load_tick && (dir ^ cfg.pol) &&
      count == RH_MAX |=> count == RH_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("counter passed its upper limit");

  property p_step;
    step_tick && !set_wr && !load_tick && !(dir ^ cfg.pol) &&
      count != RH_MIN |=> count == $past(count) - 10'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("down step did not decrement");

  c_load_path: cover property (load_tick && cfg.path && !set_wr);
endmodule // npw_rheostat

// file: core/npw_converter.sv
`timescale 1ns/10ps
module npw_converter
  import npw_pkg::*;
#(
  parameter logic [9:0] RH0_INIT = RH_INIT_RESET,
  parameter logic [9:0] RH1_INIT = RH_INIT_RESET
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // matrix side
  input wire npw_matrix_in_s mi,
  output logic [7:0] gen_data,
  output logic [1:0] rh_limit,
  output logic [9:0] rh0_count,
  output logic [9:0] rh1_count
);
  typedef struct packed {
    npw_gen_e gs;
    logic [7:0] ptr;
    logic [2:0] sub;
    logic [7:0] gen_data;
    logic [7:0] start;
    logic [7:0] ctrl;
    logic [9:0] init0;
    logic [9:0] init1;
    logic [PAT_BYTES-1:0][7:0] mem;
    logic gen_prev;
    logic [1:0] load_prev;
    logic [1:0] step_prev;
    logic [1:0] limit;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } npw_top_s;

  npw_top_s q;
  npw_top_s next_q;
  npw_conv_e mode;
  logic tick;
  logic [1:0] load_tick;
  logic [1:0] step_tick;
  logic [5:0] midx;
  logic [7:0] cur_byte;
  logic sub_done;
  logic [9:0] idx;
  logic [5:0] widx;
  logic addr_ok;
  logic wr_en;
  logic [9:0] set0;
  logic [9:0] set1;
  npw_rh_cfg_s cfg0;
  npw_rh_cfg_s cfg1;

  // edge detects on matrix inputs and byte fetch
  always_comb begin
    mode = npw_conv_e'(q.ctrl[CTRL_MODE_LSB +: 2]);
    tick = mi.gen_clk & ~q.gen_prev;
    load_tick = mi.load & ~q.load_prev;
    step_tick = mi.step & ~q.step_prev;
    midx = 6'(q.ptr - PAT_FIRST);
    cur_byte = q.mem[midx];
    sub_done = q.sub >= npw_last_sub(mode);
    idx = paddr[ADDR_W-1:2];
    widx = 6'(idx - IDX_PAT_FIRST);
    addr_ok = (paddr[1:0] == 2'b00) &&
      (idx <= IDX_RH1_CNT || idx == IDX_START ||
       (idx >= IDX_PAT_FIRST && idx <= IDX_PAT_LAST));
    wr_en = psel & penable & q.pready & pwrite & ~q.pslverr;
  end

  // rheostat configuration from control bits
  always_comb begin
    cfg0.path = q.ctrl[CTRL_PATH0];
    cfg0.align = q.ctrl[CTRL_ALIGN];
    cfg0.pol = q.ctrl[CTRL_POL0];
    cfg1.path = q.ctrl[CTRL_PATH1];
    cfg1.align = q.ctrl[CTRL_ALIGN];
    cfg1.pol = q.ctrl[CTRL_POL1];
  end

  // next state: generator, bus and input history
  always_comb begin
    next_q = q;
    next_q.gen_prev = mi.gen_clk;
    next_q.load_prev = mi.load;
    next_q.step_prev = mi.step;
    next_q.limit[0] = (rh0_count == RH_MAX) || (rh0_count == RH_MIN);
    next_q.limit[1] = (rh1_count == RH_MAX) || (rh1_count == RH_MIN);
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    // generator
    if (!mi.pattern_reset_n) begin
      next_q.gs = GS_START;
      next_q.ptr = PAT_FIRST;
      next_q.sub = 3'h0;
      next_q.gen_data = q.start;
    end else if (tick) begin
      case (q.gs)
        GS_START, GS_RUN, GS_HOLD: begin
          next_q.gen_data = npw_subword(cur_byte, mode, q.sub);
          next_q.gs = GS_RUN;
          if (sub_done) begin
            next_q.sub = 3'h0;
            if (q.ptr != PAT_LAST) begin
              next_q.ptr = q.ptr + 8'h01;
            end else if (q.ctrl[CTRL_WRAP]) begin
              next_q.gs = GS_HOLD;
            end else begin
              next_q.ptr = PAT_FIRST;
            end
          end else begin
            next_q.sub = q.sub + 3'h1;
          end
        end
        default: begin
          next_q.gs = GS_START;
        end
      endcase
    end
    // apb access phase: one wait state, then answer
    if (psel && penable && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.pslverr = ~addr_ok;
      next_q.prdata = 32'h0000_0000;
      if (addr_ok) begin
        if (idx == IDX_CTRL) begin
          next_q.prdata = {24'h00_0000, q.ctrl};
        end else if (idx == IDX_STATUS) begin
          next_q.prdata = {16'h0000, q.limit, q.gs, q.sub, q.ptr};
        end else if (idx == IDX_RHEOSTAT0_SETTING) begin
          next_q.prdata = {22'h00_0000, set0};
        end else if (idx == IDX_RHEOSTAT1_SETTING) begin
          next_q.prdata = {22'h00_0000, set1};
        end else if (idx == IDX_RH0_INIT) begin
          next_q.prdata = {22'h00_0000, q.init0};
        end else if (idx == IDX_RH1_INIT) begin
          next_q.prdata = {22'h00_0000, q.init1};
        end else if (idx == IDX_RH0_CNT) begin
          next_q.prdata = {22'h00_0000, rh0_count};
        end else if (idx == IDX_RH1_CNT) begin
          next_q.prdata = {22'h00_0000, rh1_count};
        end else if (idx == IDX_START) begin
          next_q.prdata = {24'h00_0000, q.start};
        end else begin
          next_q.prdata = {24'h00_0000, q.mem[widx]};
        end
      end
    end
    // writes take effect at the completing edge
    if (wr_en) begin
      if (idx == IDX_CTRL) begin
        next_q.ctrl = pwdata[7:0];
      end else if (idx == IDX_RH0_INIT) begin
        next_q.init0 = pwdata[9:0];
      end else if (idx == IDX_RH1_INIT) begin
        next_q.init1 = pwdata[9:0];
      end else if (idx == IDX_START) begin
        next_q.start = pwdata[7:0];
      end else if (idx >= IDX_PAT_FIRST && idx <= IDX_PAT_LAST) begin
        next_q.mem[widx] = pwdata[7:0];
      end
    end
  end

  // state register; power-up shows the start value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.gs <= GS_START;
      q.ptr <= PAT_FIRST;
      q.gen_data <= START_RESET;
      q.start <= START_RESET;
      q.ctrl <= CTRL_RESET;
      q.init0 <= RH0_INIT;
      q.init1 <= RH1_INIT;
    end else begin
      q <= next_q;
    end
  end

  // two rheostat counters
  npw_rheostat #(.INIT_RESET(RH0_INIT)) u_rh0 (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg0),
    .gen_data(q.gen_data),
    .init_value(q.init0),
    .load_tick(load_tick[0]),
    .step_tick(step_tick[0]),
    .dir(mi.dir[0]),
    .set_wr(wr_en && idx == IDX_RHEOSTAT0_SETTING),
    .set_data(pwdata[9:0]),
    .setting(set0),
    .count(rh0_count)
  );

  npw_rheostat #(.INIT_RESET(RH1_INIT)) u_rh1 (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg1),
    .gen_data(q.gen_data),
    .init_value(q.init1),
    .load_tick(load_tick[1]),
    .step_tick(step_tick[1]),
    .dir(mi.dir[1]),
    .set_wr(wr_en && idx == IDX_RHEOSTAT1_SETTING),
    .set_data(pwdata[9:0]),
    .setting(set1),
    .count(rh1_count)
  );

  // outputs
  assign gen_data = q.gen_data;
  assign rh_limit = q.limit;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

  // fetched byte one cycle back, for checking
  logic [7:0] cur_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_d <= 8'h00;
    end else begin
      cur_d <= cur_byte;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reset_start;
    !mi.pattern_reset_n |=> gen_data == $past(q.start) && q.ptr == PAT_FIRST;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("pattern reset did not load start value");

  property p_wrap;
    mi.pattern_reset_n && tick && sub_done && q.ptr == PAT_LAST &&
      !q.ctrl[CTRL_WRAP] |=> q.ptr == PAT_FIRST;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap");

  property p_stop;
    mi.pattern_reset_n && q.ptr == PAT_LAST && q.ctrl[CTRL_WRAP]
      |=> q.ptr == PAT_LAST;
  endproperty
  a_stop: assert property (p_stop)
    else $error("pointer left last byte in stop mode");

  property p_byte_out;
    mi.pattern_reset_n && tick && mode == CONV_BYTE |=> gen_data == cur_d;
  endproperty
  a_byte_out: assert property (p_byte_out)
    else $error("byte mode output wrong");

  property p_nibble;
    mi.pattern_reset_n && tick && mode == CONV_NIBBLE && q.sub == 3'h0
      |=> gen_data == {4'h0, cur_d[7:4]};
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("first nibble is not the high one");

  property p_pair;
    mi.pattern_reset_n && tick && mode == CONV_PAIR && q.sub == 3'h3
      |=> gen_data == {6'h00, cur_d[1:0]};
  endproperty
  a_pair: assert property (p_pair)
    else $error("last pair is not the low one");

  property p_serial;
    mi.pattern_reset_n && tick && mode == CONV_SERIAL && q.sub == 3'h0
      |=> gen_data == {7'h00, cur_d[7]};
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial stream not msb first");

  property p_advance;
    mi.pattern_reset_n && tick && sub_done && q.ptr != PAT_LAST
      |=> q.ptr == $past(q.ptr) + 8'h01;
  endproperty
  a_advance: assert property (p_advance)
    else $error("pointer did not advance after byte");

  property p_apb_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer missing");

  c_serial_wrap: cover property (tick && mode == CONV_SERIAL &&
    q.ptr == PAT_LAST && sub_done && !q.ctrl[CTRL_WRAP]);
  c_hold: cover property (q.gs == GS_HOLD);
  c_apb_err: cover property (pready && pslverr);
endmodule // npw_converter

// file: bench/npw_matrix_model.sv
`timescale 1ns/10ps
module npw_matrix_model
  import npw_pkg::*;
(
  // clock
  input wire logic pclk,
  // matrix signals toward the converter
  output npw_matrix_in_s mi
);
  // idle levels: clocks and strobes low, pattern reset released
  initial begin
    mi = '0;
    mi.pattern_reset_n = 1'b1;
  end

  // one generator clock period; caller keeps the rate within the mode limit
  task automatic gen_tick(input int half);
    mi.gen_clk <= 1'b1;
    repeat (half) @(posedge pclk);
    mi.gen_clk <= 1'b0;
    repeat (half) @(posedge pclk);
  endtask

  // pattern reset pulse, then a short settle
  task automatic restart();
    mi.pattern_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    mi.pattern_reset_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // load or step strobe on one rheostat, direction set with it
  task automatic strobe(input bit is_load, input int i, input bit up);
    mi.dir[i] <= up;
    if (is_load) mi.load[i] <= 1'b1;
    else mi.step[i] <= 1'b1;
    repeat (2) @(posedge pclk);
    mi.load[i] <= 1'b0;
    mi.step[i] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule // npw_matrix_model

// file: bench/npw_converter_bench.sv
`timescale 1ns/10ps
module npw_converter_bench
  import npw_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] gen_data;
  logic [1:0] rh_limit;
  logic [9:0] rh0_count, rh1_count;
  npw_matrix_in_s mi;
  int n_fail, checked;
  logic [9:0] x;

  npw_converter i_npw_converter (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mi(mi), .gen_data(gen_data), .rh_limit(rh_limit),
    .rh0_count(rh0_count), .rh1_count(rh1_count));
  npw_matrix_model i_npw_matrix_model (.pclk(pclk), .mi(mi));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic fail(string m);
    n_fail++;
    $display("FAIL %0t %s", $time, m);
  endtask

  task automatic cmp(logic [31:0] got, logic [31:0] exp, string m);
    checked++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // apb transfer: setup, access, hold until pready sampled high
  task automatic apb(bit wr, logic [9:0] idx, logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) fail("no pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] pat(int k);
    pat = 8'(k * 37 + 19);
  endfunction

  // reset values at the ports and in the registers
  task automatic t_reset();
    cmp(32'(gen_data), 32'(START_RESET), "start out");
    cmp(32'(rh0_count), 32'(RH_INIT_RESET), "rh0 init");
    cmp(32'(rh1_count), 32'(RH_INIT_RESET), "rh1 init");
    apb(0, IDX_CTRL, 0);
    cmp(rd, 32'(CTRL_RESET), "ctrl reset");
    apb(0, IDX_RHEOSTAT1_SETTING, 0);
    cmp(rd, 32'(RH_INIT_RESET), "rheostat1_setting reset");
    cmp(32'(rh_limit), 32'h0000_0003, "limits at zero");
  endtask

  // store start value and pattern, probe an unmapped place
  task automatic t_fill();
    apb(1, IDX_START, 32'h0000_00a5);
    for (int k = 0; k < PAT_BYTES; k++) apb(1, IDX_PAT_FIRST + 10'(k), pat(k));
    apb(0, IDX_PAT_LAST, 0);
    cmp(rd, 32'(pat(58)), "last byte");
    apb(1, 10'h0fd, 32'h0000_00ff);
    cmp(32'(er), 1, "unmapped write err");
    apb(0, 10'h0fd, 0);
    cmp(32'(er), 1, "unmapped read err");
    cmp(rd, 0, "unmapped read data");
  endtask

  // byte mode over the whole range, then wrap or stop
  task automatic t_byte(bit wrap);
    apb(1, IDX_CTRL, 32'(wrap) << CTRL_WRAP);
    i_npw_matrix_model.restart();
    cmp(32'(gen_data), 32'h0000_00a5, "restart value");
    for (int k = 0; k < PAT_BYTES; k++) begin
      i_npw_matrix_model.gen_tick(63);
      cmp(32'(gen_data), 32'(pat(k)), "byte");
    end
    i_npw_matrix_model.gen_tick(63);
    cmp(32'(gen_data), 32'(wrap ? pat(58) : pat(0)), "range end");
    i_npw_matrix_model.gen_tick(63);
    cmp(32'(gen_data), 32'(wrap ? pat(58) : pat(1)), "after end");
    // pointer and state after the range end, both counters at zero
    apb(0, IDX_STATUS, 0);
    cmp(rd, {16'h0000, 2'b11, wrap ? GS_HOLD : GS_RUN, 3'h0,
      wrap ? PAT_LAST : PAT_FIRST + 8'h02}, "status");
  endtask

  // split and serial modes, most significant part first
  task automatic t_split();
    int w;
    int e;
    for (int m = 1; m < 4; m++) begin
      w = 8 >> m;
      apb(1, IDX_CTRL, 32'(m));
      i_npw_matrix_model.restart();
      for (int k = 0; k < 2; k++)
        for (int s = 0; s < 8 / w; s++) begin
          i_npw_matrix_model.gen_tick(63 >> m);
          e = (int'(pat(k)) >> (8 - w * (s + 1))) & ((1 << w) - 1);
          cmp(32'(gen_data), 32'(e), "subword");
        end
    end
  endtask

  // rheostat loads, steps, writes and saturation
  task automatic t_rheo();
    x = {pat(58), 2'b00};
    apb(1, IDX_CTRL, 32'(1) << CTRL_PATH0);
    i_npw_matrix_model.strobe(1, 0, 0);
    cmp(32'(rh0_count), 32'(x), "load msb");
    cmp(32'(rh1_count), 32'(RH_INIT_RESET), "rh1 untouched");
    apb(1, IDX_CTRL, 32'h0000_0028);
    i_npw_matrix_model.strobe(1, 1, 0);
    cmp(32'(rh1_count), 32'({2'b00, pat(58)}), "load lsb");
    apb(1, IDX_CTRL, 32'(1) << CTRL_POL1);
    i_npw_matrix_model.strobe(0, 1, 0);
    cmp(32'(rh1_count), 32'({2'b00, pat(58)}) + 1, "rh1 inv step");
    i_npw_matrix_model.strobe(0, 0, 1);
    cmp(32'(rh0_count), 32'(x + 10'h001), "step up");
    apb(1, IDX_CTRL, 32'h0000_0050);
    i_npw_matrix_model.strobe(0, 0, 1);
    cmp(32'(rh0_count), 32'(x), "inverted step");
    apb(1, IDX_RHEOSTAT0_SETTING, 32'h0000_03ff);
    // the write lands at the completing edge; look one edge later
    @(posedge pclk);
    cmp(32'(rh0_count), 32'(RH_MAX), "set write");
    apb(1, IDX_CTRL, 0);
    i_npw_matrix_model.strobe(0, 0, 1);
    cmp(32'(rh0_count), 32'(RH_MAX), "top saturate");
    cmp(32'(rh_limit[0]), 1, "top flag");
    apb(1, IDX_RHEOSTAT0_SETTING, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    cmp(32'(rh_limit[0]), 0, "flag clear");
    i_npw_matrix_model.strobe(0, 0, 0);
    i_npw_matrix_model.strobe(0, 0, 0);
    cmp(32'(rh0_count), 32'(RH_MIN), "bottom saturate");
    cmp(32'(rh_limit[0]), 1, "bottom flag");
    apb(1, IDX_RH0_INIT, 32'h0000_02c7);
    i_npw_matrix_model.strobe(1, 0, 0);
    cmp(32'(rh0_count), 32'h0000_02c7, "reload init");
    apb(0, IDX_RHEOSTAT0_SETTING, 0);
    cmp(rd, 32'h0000_02c7, "reload setting");
    apb(1, IDX_RH0_CNT, 32'h0000_0123);
    apb(0, IDX_RH0_CNT, 0);
    cmp(rd, 32'h0000_02c7, "count read only");
  endtask

  // watchdog on the whole run
  initial begin
    repeat (60000) @(posedge pclk);
    fail("timeout");
    summarize();
  end

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fill();
    t_byte(0);
    t_byte(1);
    t_rheo();
    t_split();
    summarize();
  end
endmodule // npw_converter_bench
